// ===== rtl/frtc_defines.svh
`ifndef FRTC_DEFINES_SVH
`define FRTC_DEFINES_SVH
// Functional notes
// - A 12-bit counter runs continuously, advancing on each 1 MHz tick from the clock.
// - Counter gives periodic 128 us and 1.024 ms requests, each gated by an enable.
// - The present counter value is readable at any time for elapsed-time subtraction.
// - An edge on a capture input copies a selected 8-bit counter slice into its register.
// - Four 8-bit capture registers: a rising and a falling one per capture input.
// - The capture timebase select offers exactly five prescale settings choosing the slice.
// - Each capture timer raises a request whenever a selected edge latched a new value.
// - Port 0 bit 0 feeds capture timer A, port 0 bit 1 feeds capture timer B.
// - Timer, both capture timers and wake-up timer are individually maskable requests.
// - A wake-up timer runs while suspended and produces periodic wake-up events.
// - A guard timer resets operation unless firmware services it within about 8 ms.

`define FRTC_CLK_HZ 125000000
`define FRTC_TICK_HZ 1000000
`define FRTC_TICK_DIV (`FRTC_CLK_HZ / `FRTC_TICK_HZ)
`define FRTC_DIV_W 7
`define FRTC_TICK_NS (1000000000 / `FRTC_TICK_HZ)

`define FRTC_CNT_W 12
`define FRTC_CAP_W 8
`define FRTC_SEL_W 3
`define FRTC_PRESCALE_N 5

`define FRTC_FAST_IRQ_NS 128000
`define FRTC_SLOW_IRQ_NS 1024000
`define FRTC_FAST_TICKS (`FRTC_FAST_IRQ_NS / `FRTC_TICK_NS)
`define FRTC_SLOW_TICKS (`FRTC_SLOW_IRQ_NS / `FRTC_TICK_NS)

`define FRTC_GUARD_MS 8
`define FRTC_GUARD_TICKS (`FRTC_GUARD_MS * 1000000 / `FRTC_TICK_NS)
`define FRTC_WAKE_TICKS_DEF 1024
`define FRTC_PERIOD_W 16

`define FRTC_CAP_RST 8'h00
`define FRTC_CNT_RST 12'h000
`endif

// ===== rtl/frtc_pkg.sv
`include "frtc_defines.svh"
package frtc_pkg;
   typedef struct packed {
      logic rise_en;
      logic fall_en;
      logic irq_en;
   } frtc_cap_cfg_s;

   typedef struct packed {
      logic fast;
      logic slow;
      logic cap_a;
      logic cap_b;
      logic wake;
   } frtc_irq_s;

   typedef struct packed {
      logic armed;
      logic prev;
      logic [`FRTC_CAP_W-1:0] rise;
      logic [`FRTC_CAP_W-1:0] fall;
      logic irq;
   } frtc_cap_state_s;

   typedef struct packed {
      logic [`FRTC_DIV_W-1:0] div;
      logic [`FRTC_CNT_W-1:0] cnt;
      logic [`FRTC_CNT_W-1:0] snap;
      logic fast_irq;
      logic slow_irq;
      logic wake_irq;
      logic [`FRTC_PERIOD_W-1:0] wake_cnt;
      logic [`FRTC_PERIOD_W-1:0] guard_cnt;
      logic guard_rst;
      logic guard_fired;
   } frtc_state_s;
endpackage

// ===== rtl/frtc_capture.sv
`timescale 1ns/1ps
`include "frtc_defines.svh"
module frtc_capture (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic pin_in,
   input wire logic [`FRTC_CAP_W-1:0] slice_in,
   input frtc_pkg::frtc_cap_cfg_s cfg_in,
   output logic [`FRTC_CAP_W-1:0] rise_out,
   output logic [`FRTC_CAP_W-1:0] fall_out,
   output logic irq_out
);
   import frtc_pkg::*;

   frtc_cap_state_s st_q;
   frtc_cap_state_s st_d;
   logic rise_edge;
   logic fall_edge;

   always_comb begin
      st_d = st_q;
      st_d.irq = 1'b0;
      st_d.prev = pin_in;
      st_d.armed = 1'b1;
      // No edge before the first sample, so a pin high at reset is not a rising edge
      rise_edge = st_q.armed & pin_in & ~st_q.prev;
      fall_edge = st_q.armed & ~pin_in & st_q.prev;
      if (rise_edge && cfg_in.rise_en) begin
         st_d.rise = slice_in;
      end
      if (fall_edge && cfg_in.fall_en) begin
         st_d.fall = slice_in;
      end
      st_d.irq = cfg_in.irq_en & ((rise_edge & cfg_in.rise_en)
                 | (fall_edge & cfg_in.fall_en));
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= '{armed: 1'b0, prev: 1'b0, rise: `FRTC_CAP_RST, fall: `FRTC_CAP_RST, irq: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign rise_out = st_q.rise;
   assign fall_out = st_q.fall;
   assign irq_out = st_q.irq;
endmodule

// ===== rtl/frtc_top.sv
`timescale 1ns/1ps
`include "frtc_defines.svh"
module frtc_top #(
   parameter int unsigned GUARD_TICKS = `FRTC_GUARD_TICKS,
   parameter int unsigned WAKE_TICKS = `FRTC_WAKE_TICKS_DEF,
   parameter int unsigned TICK_DIV = `FRTC_TICK_DIV
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic capture_input_a_pin_in,
   input wire logic capture_input_b_pin_in,
   input wire logic fast_irq_en_in,
   input wire logic slow_irq_en_in,
   input wire logic [`FRTC_SEL_W-1:0] prescale_sel_in,
   input frtc_pkg::frtc_cap_cfg_s cap_cfg_a_in,
   input frtc_pkg::frtc_cap_cfg_s cap_cfg_b_in,
   input wire logic count_snap_in,
   input wire logic suspend_in,
   input wire logic wake_irq_en_in,
   input wire logic stall_guard_en_in,
   input wire logic stall_guard_service_in,
   output logic [`FRTC_CNT_W-1:0] count_out,
   output logic [`FRTC_CNT_W-1:0] count_snap_out,
   output logic [`FRTC_CAP_W-1:0] cap_a_rise_out,
   output logic [`FRTC_CAP_W-1:0] cap_a_fall_out,
   output logic [`FRTC_CAP_W-1:0] cap_b_rise_out,
   output logic [`FRTC_CAP_W-1:0] cap_b_fall_out,
   output frtc_pkg::frtc_irq_s irq_req_out,
   output logic stall_guard_reset_out,
   output logic stall_guard_fired_out
);
   import frtc_pkg::*;

   localparam logic [`FRTC_DIV_W-1:0] DIV_LAST = `FRTC_DIV_W'(TICK_DIV - 1);
   localparam logic [`FRTC_PERIOD_W-1:0] GUARD_LAST = `FRTC_PERIOD_W'(GUARD_TICKS - 1);
   localparam logic [`FRTC_PERIOD_W-1:0] WAKE_LAST = `FRTC_PERIOD_W'(WAKE_TICKS - 1);
   localparam logic [`FRTC_SEL_W-1:0] SEL_MAX = `FRTC_SEL_W'(`FRTC_PRESCALE_N - 1);

   frtc_state_s st_q;
   frtc_state_s st_d;
   logic tick;
   logic [`FRTC_CAP_W-1:0] slice;
   logic [1:0] cap_pin;
   frtc_cap_cfg_s cap_cfg [2];
   logic [`FRTC_CAP_W-1:0] cap_rise [2];
   logic [`FRTC_CAP_W-1:0] cap_fall [2];
   logic [1:0] cap_irq;

   // True on the last count of a period; periods are powers of two so this
   // lines up with the counter's own rollover and needs no extra divider
   function automatic logic phase_end(input logic [`FRTC_CNT_W-1:0] c,
                                      input int unsigned period);
      phase_end = ((int'(c) + 1) % period) == 0;
   endfunction

   // Five timebases: the slice starts at bit 0..4 of the counter; selects above
   // the last setting fall back to the slowest one rather than reading zero
   function automatic logic [`FRTC_CAP_W-1:0] timebase_slice(
         input logic [`FRTC_CNT_W-1:0] c,
         input logic [`FRTC_SEL_W-1:0] sel);
      logic [`FRTC_SEL_W-1:0] sh;
      logic [`FRTC_CNT_W-1:0] shifted;
      sh = (sel > SEL_MAX) ? SEL_MAX : sel;
      shifted = c >> sh;
      timebase_slice = shifted[`FRTC_CAP_W-1:0];
   endfunction

   assign slice = timebase_slice(st_q.cnt, prescale_sel_in);
   assign cap_pin = {capture_input_b_pin_in, capture_input_a_pin_in};
   assign cap_cfg[0] = cap_cfg_a_in;
   assign cap_cfg[1] = cap_cfg_b_in;

   generate
      for (genvar i = 0; i < 2; i++) begin : g_cap
         frtc_capture u_cap (
            .mclk_in(mclk_in),
            .rst_n_in(rst_n_in),
            .pin_in(cap_pin[i]),
            .slice_in(slice),
            .cfg_in(cap_cfg[i]),
            .rise_out(cap_rise[i]),
            .fall_out(cap_fall[i]),
            .irq_out(cap_irq[i])
         );
      end
   endgenerate

   always_comb begin
      st_d = st_q;
      tick = 1'b0;
      st_d.fast_irq = 1'b0;
      st_d.slow_irq = 1'b0;
      st_d.wake_irq = 1'b0;
      st_d.guard_rst = 1'b0;

      if (st_q.div == DIV_LAST) begin
         st_d.div = '0;
         tick = 1'b1;
      end else begin
         st_d.div = st_q.div + `FRTC_DIV_W'(1);
      end

      if (tick) begin
         // Plain increment: all ones rolls to zero and counting goes on
         st_d.cnt = st_q.cnt + `FRTC_CNT_W'(1);
         st_d.fast_irq = fast_irq_en_in & phase_end(st_q.cnt, `FRTC_FAST_TICKS);
         st_d.slow_irq = slow_irq_en_in & phase_end(st_q.cnt, `FRTC_SLOW_TICKS);
      end

      // Firmware reads of a wide value over a narrow path tear; the snapshot
      // gives a coherent copy, while count_out stays live
      if (count_snap_in) begin
         st_d.snap = st_q.cnt;
      end

      if (!suspend_in) begin
         st_d.wake_cnt = '0;
      end else if (tick) begin
         if (st_q.wake_cnt >= WAKE_LAST) begin
            st_d.wake_cnt = '0;
            st_d.wake_irq = wake_irq_en_in;
         end else begin
            st_d.wake_cnt = st_q.wake_cnt + `FRTC_PERIOD_W'(1);
         end
      end

      // Guard holds still in suspend so a long sleep does not fire it
      if (!stall_guard_en_in || stall_guard_service_in) begin
         st_d.guard_cnt = '0;
      end else if (tick && !suspend_in) begin
         if (st_q.guard_cnt >= GUARD_LAST) begin
            st_d.guard_cnt = '0;
            st_d.guard_rst = 1'b1;
         end else begin
            st_d.guard_cnt = st_q.guard_cnt + `FRTC_PERIOD_W'(1);
         end
      end

      // Sticky cause flag: set by a timeout, cleared by a service; a service also blocks any timeout in its cycle
      if (st_d.guard_rst) begin
         st_d.guard_fired = 1'b1;
      end else if (stall_guard_service_in) begin
         st_d.guard_fired = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q <= '{div: '0, cnt: `FRTC_CNT_RST, snap: `FRTC_CNT_RST,
                   fast_irq: 1'b0, slow_irq: 1'b0, wake_irq: 1'b0,
                   wake_cnt: '0, guard_cnt: '0, guard_rst: 1'b0, guard_fired: 1'b0};
      end else begin
         st_q <= st_d;
      end
   end

   assign count_out = st_q.cnt;
   assign count_snap_out = st_q.snap;
   assign cap_a_rise_out = cap_rise[0];
   assign cap_a_fall_out = cap_fall[0];
   assign cap_b_rise_out = cap_rise[1];
   assign cap_b_fall_out = cap_fall[1];
   assign irq_req_out = {st_q.fast_irq, st_q.slow_irq, cap_irq[0], cap_irq[1], st_q.wake_irq};
   assign stall_guard_reset_out = st_q.guard_rst;
   assign stall_guard_fired_out = st_q.guard_fired;
endmodule

// ===== test/frtc_top_sva.sv
`timescale 1ns/1ps
`include "frtc_defines.svh"
module frtc_top_sva (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic capture_input_a_pin_in,
   input wire logic capture_input_b_pin_in,
   input wire logic fast_irq_en_in,
   input wire logic slow_irq_en_in,
   input wire logic [`FRTC_SEL_W-1:0] prescale_sel_in,
   input frtc_pkg::frtc_cap_cfg_s cap_cfg_a_in,
   input frtc_pkg::frtc_cap_cfg_s cap_cfg_b_in,
   input wire logic count_snap_in,
   input wire logic suspend_in,
   input wire logic [`FRTC_CNT_W-1:0] count_out,
   input wire logic [`FRTC_CNT_W-1:0] count_snap_out,
   input wire logic [`FRTC_CAP_W-1:0] cap_a_rise_out,
   input wire logic [`FRTC_CAP_W-1:0] cap_b_fall_out,
   input frtc_pkg::frtc_irq_s irq_req_out,
   input wire logic stall_guard_reset_out,
   input wire logic stall_guard_fired_out
);
   import frtc_pkg::*;
   logic [7:0] slice;
   logic pa;
   assign slice = 8'(count_out >> (prescale_sel_in > 3'h4 ? 3'h4 : prescale_sel_in));
   assign pa = capture_input_a_pin_in;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);
   count_step_a: assert property ($changed(count_out)
      |-> count_out == $past(count_out) + 12'h001)
      else $error("counter step wrong");
   count_hold_a: assert property ($changed(count_out) |=> $stable(count_out) [*8])
      else $error("counter moved too soon");
   fast_src_a: assert property (irq_req_out.fast
      |-> count_out[6:0] == 7'h00 && $past(fast_irq_en_in))
      else $error("fast request out of place");
   fast_cause_a: assert property (($changed(count_out) && count_out[6:0] == 7'h00
      && $past(fast_irq_en_in)) |-> irq_req_out.fast)
      else $error("fast request missing");
   slow_src_a: assert property (irq_req_out.slow
      |-> count_out[9:0] == 10'h000 && $past(slow_irq_en_in))
      else $error("slow request out of place");
   slow_cause_a: assert property (($changed(count_out) && count_out[9:0] == 10'h000
      && $past(slow_irq_en_in)) |-> irq_req_out.slow)
      else $error("slow request missing");
   cap_rise_a: assert property ((pa && !$past(pa) && cap_cfg_a_in.rise_en)
      |=> cap_a_rise_out == $past(slice))
      else $error("rise capture wrong");
   cap_fall_a: assert property ((!capture_input_b_pin_in
      && $past(capture_input_b_pin_in) && cap_cfg_b_in.fall_en)
      |=> cap_b_fall_out == $past(slice))
      else $error("fall capture wrong");
   cap_irq_a: assert property ((pa != $past(pa) && cap_cfg_a_in.irq_en
      && (pa ? cap_cfg_a_in.rise_en : cap_cfg_a_in.fall_en)) |=> irq_req_out.cap_a)
      else $error("capture request missing");
   guard_flag_a: assert property (stall_guard_reset_out |-> stall_guard_fired_out)
      else $error("guard flag not set");
   wake_src_a: assert property (irq_req_out.wake |-> $past(suspend_in))
      else $error("wake outside suspend");
   snap_copy_a: assert property (count_snap_in |=> count_snap_out == $past(count_out))
      else $error("snapshot value wrong");
endmodule
bind frtc_top frtc_top_sva frtc_top_sva_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
   .capture_input_a_pin_in(capture_input_a_pin_in),
   .capture_input_b_pin_in(capture_input_b_pin_in),
   .fast_irq_en_in(fast_irq_en_in), .slow_irq_en_in(slow_irq_en_in),
   .prescale_sel_in(prescale_sel_in), .cap_cfg_a_in(cap_cfg_a_in), .cap_cfg_b_in(cap_cfg_b_in),
   .count_snap_in(count_snap_in), .suspend_in(suspend_in), .count_out(count_out),
   .count_snap_out(count_snap_out), .cap_a_rise_out(cap_a_rise_out),
   .cap_b_fall_out(cap_b_fall_out), .irq_req_out(irq_req_out),
   .stall_guard_reset_out(stall_guard_reset_out),
   .stall_guard_fired_out(stall_guard_fired_out));

// ===== test/frtc_pin_src.sv
`timescale 1ns/1ps
module frtc_pin_src (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [1:0] go_in,
   output logic [1:0] pin_out
);
   // Pins idle low and toggle once per request cycle, so held requests give back-to-back edges
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) pin_out <= 2'h0;
      else pin_out <= pin_out ^ go_in;
   end
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
   import frtc_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic fen = 1'b0, sen = 1'b0, snap = 1'b0, susp = 1'b0, wen = 1'b0, gen = 1'b0, gsrv = 1'b0;
   logic [2:0] sel = 3'h0;
   logic [1:0] go = 2'h0, pin, lvl = 2'h0;
   frtc_cap_cfg_s ca = '0, cb = '0;
   frtc_irq_s irq;
   logic [11:0] ecnt, cnt, snapo;
   logic [6:0] ediv;
   logic [7:0] ar, af, br, bf;
   logic grst, gfir;
   logic [9:0] q[$];
   int seed = 20, n_fail = 0, n_checks = 0;
   // A short tick brings the slow request and the counter wrap into a bearable run
   localparam int TDIV = 10;
   localparam int GTICKS = 4;
   localparam int WTICKS = 4;
   frtc_top #(.GUARD_TICKS(GTICKS), .WAKE_TICKS(WTICKS), .TICK_DIV(TDIV)) frtc_top_i (
      .mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .capture_input_a_pin_in(pin[0]), .capture_input_b_pin_in(pin[1]), .fast_irq_en_in(fen),
      .slow_irq_en_in(sen), .prescale_sel_in(sel), .cap_cfg_a_in(ca), .cap_cfg_b_in(cb),
      .count_snap_in(snap), .suspend_in(susp), .wake_irq_en_in(wen), .stall_guard_en_in(gen),
      .stall_guard_service_in(gsrv), .count_out(cnt), .count_snap_out(snapo),
      .cap_a_rise_out(ar), .cap_a_fall_out(af), .cap_b_rise_out(br), .cap_b_fall_out(bf),
      .irq_req_out(irq), .stall_guard_reset_out(grst), .stall_guard_fired_out(gfir));
   frtc_pin_src frtc_pin_src_i (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .go_in(go), .pin_out(pin));
   initial begin
      forever #4 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in) begin
      if (!rst_n_in) begin
         ediv <= 7'h00;
         ecnt <= 12'h000;
      end else if (ediv == 7'(TDIV - 1)) begin
         ediv <= 7'h00;
         ecnt <= ecnt + 12'h001;
      end else ediv <= ediv + 7'h01;
   end
   task automatic close_out;
      if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic take(input logic ch);
      logic [9:0] e;
      logic [7:0] got;
      n_checks++;
      e = (q.size() > 0) ? q.pop_front() : {~ch, 9'h000};
      got = ch ? (e[8] ? br : bf) : (e[8] ? ar : af);
      if ({ch, got} !== {e[9], e[7:0]}) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {ch, got}, {e[9], e[7:0]});
      end
   endtask
   always @(negedge mclk_in) begin
      if (irq.cap_a === 1'b1) take(1'b0);
      if (irq.cap_b === 1'b1) take(1'b1);
      if (rst_n_in) begin
         n_checks++;
         if (cnt !== ecnt) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, cnt, ecnt);
         end
      end
   end
   // Expected slice comes from the bench's own counter copy, never from the design
   task automatic pulse(input logic ch, input int n);
      frtc_cap_cfg_s cf;
      logic [7:0] v;
      if (n > 0) @(posedge mclk_in) go[ch] <= 1'b1;
      for (int i = 0; i < n; i++) begin
         @(posedge mclk_in);
         if (i == n - 1) go[ch] <= 1'b0;
         #1 lvl[ch] = ~lvl[ch];
         // Read after the edge so the configuration set in the caller's cycle is seen
         cf = ch ? cb : ca;
         v = 8'(ecnt >> (sel > 3'h4 ? 3'h4 : sel));
         if (cf.irq_en && (lvl[ch] ? cf.rise_en : cf.fall_en)) q.push_back({ch, lvl[ch], v});
      end
   endtask
   // Cycles up to the next guard (ev 0) or wake (ev 1) pulse; want 0 only asks that one comes
   task automatic gap(input logic ev, input int want);
      int n;
      n = 0;
      do begin
         @(negedge mclk_in);
         n++;
      end while (((ev ? irq.wake : grst) !== 1'b1) && n < 400);
      n_checks++;
      if ((want > 0) ? (n != want) : (n >= 400)) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, n, want);
      end
   endtask
   initial begin
      repeat (20) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge mclk_in);
         sel <= 3'(i);
         ca <= 3'($random(seed));
         cb <= 3'($random(seed));
         {susp, wen, gen, gsrv, snap, fen, sen} <= 7'($random(seed));
         pulse(1'($random(seed)), $random(seed) & 3);
         repeat (($random(seed) & 511) + 10) @(posedge mclk_in);
      end
      @(posedge mclk_in);
      {susp, wen, gen, gsrv, fen, sen} <= 6'b001011;
      gap(1'b0, 0);
      n_checks++;
      if (gfir !== 1'b1) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gfir, 1'b1);
      end
      gap(1'b0, GTICKS * TDIV);
      @(posedge mclk_in) gsrv <= 1'b1;
      @(posedge mclk_in) gsrv <= 1'b0;
      @(negedge mclk_in);
      n_checks++;
      if (gfir !== 1'b0) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, gfir, 1'b0);
      end
      @(posedge mclk_in);
      {susp, wen} <= 2'b11;
      gap(1'b1, 0);
      gap(1'b1, WTICKS * TDIV);
      @(posedge mclk_in);
      {susp, wen, gen} <= 3'b000;
      repeat (42000) @(posedge mclk_in);
      for (int k = 0; k < 8 && q.size() > 0; k++) @(posedge mclk_in);
      if (q.size() != 0) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, q.size(), 0);
      end
      close_out();
   end
endmodule
